/* File: src/css_pkg.sv */
// constants, types and start-up decoding shared by the crystal start-up select block
package css_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the AXI4-Lite slave)
  // ----------------------------------------------------------------
  localparam int AXI_AW = 4;
  localparam int AXI_DW = 32;
  localparam logic [AXI_AW-1:0] REG_FUSE = 4'h0;
  localparam logic [AXI_AW-1:0] REG_CTRL = 4'h4;
  localparam logic [AXI_AW-1:0] REG_STATUS = 4'h8;
  localparam logic [AXI_AW-1:0] REG_COUNT = 4'hC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // fuse image, a '0' bit means programmed
  typedef struct packed {
    logic div8_n;
    logic [1:0] startup_time_fuses;
    logic [3:0] clock_source_select_fuses;
  } css_fuse_t;
  localparam int FUSE_W = 7;
  localparam css_fuse_t FUSE_RESET = 7'h22;

  // control register, write-one pulses
  localparam int CTRL_RESTART_BIT = 0;
  localparam int CTRL_SLEEP_BIT = 1;
  localparam int CTRL_WAKE_BIT = 2;

  // status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_LP_BIT = 3;
  localparam int ST_FS_BIT = 4;
  localparam int ST_RANGE_LSB = 5;
  localparam int ST_STABLE_BIT = 7;
  localparam int ST_HOLD_BIT = 8;
  localparam int ST_DIV8_BIT = 9;
  localparam int ST_WAKE_LSB = 10;
  localparam int ST_TOUT_LSB = 12;

  // ----------------------------------------------------------------
  // source decode and counts
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_FULL_SWING = 3'h3;
  localparam int SRC_LP_BIT = 3;
  localparam int WAKE_SHORT = 258;
  localparam int WAKE_MID = 1024;
  localparam int DEF_WAKE_LONG = 16384;
  localparam int TOUT_SHORT = 512;
  localparam int DEF_TOUT_LONG = 8192;
  localparam int RESET_CK = 14;
  localparam int DEF_CNT_W = 15;
  localparam int DIV_W = 3;
  localparam logic [DIV_W-1:0] DIV_LAST = 3'h7;

  typedef enum logic [1:0] {WK_258, WK_1K, WK_16K} css_wake_t;
  typedef enum logic [1:0] {TO_NONE, TO_512, TO_8K} css_tout_t;
  typedef struct packed {
    css_wake_t wake;
    css_tout_t tout;
  } css_start_t;
  typedef enum logic [2:0] {CSS_START, CSS_TOUT, CSS_RST14, CSS_RUN, CSS_SLEEP, CSS_WAKE, CSS_OFF} css_state_t;

  // lowest select bit and start-up fuses to wake count and reset time-out
  function automatic css_start_t css_decode(input logic bit0, input logic [1:0] startup_time_fuses);
    css_start_t s;
    s.wake = WK_16K;
    s.tout = TO_NONE;
    case ({bit0, startup_time_fuses})
      3'h0: s = '{WK_258, TO_512};
      3'h1: s = '{WK_258, TO_8K};
      3'h2: s = '{WK_1K, TO_NONE};
      3'h3: s = '{WK_1K, TO_512};
      3'h4: s = '{WK_1K, TO_8K};
      3'h5: s = '{WK_16K, TO_NONE};
      3'h6: s = '{WK_16K, TO_512};
      default: s = '{WK_16K, TO_8K};
    endcase
    return s;
  endfunction

endpackage

/* File: src/css_top.sv */
// crystal oscillator range select, start-up counting and divide-by-eight with an AXI4-Lite register slave
// Contract
// - low-power crystal decodes upper select bits 100..111 as four frequency ranges.
// - upper select bits 011 pick the full-swing crystal oscillator, 0.4 to 20 MHz.
// - bit0=0, start-up 00: wake 258 cycles; reset 14 cycles plus 512 watchdog cycles.
// - bit0=0, start-up 01: wake 258 cycles; reset 14 cycles plus 8K watchdog cycles.
// - bit0=0, start-up 10: wake 1K cycles; reset only 14 cycles.
// - bit0=0/11 gives 1K wake, 14 plus 4.1 ms; bit0=1/00 gives 1K, 14 plus 65 ms.
// - bit0=1, start-up 01: wake 16K cycles; reset only 14 cycles.
// - bit0=1, start-up 10: wake 16K cycles; reset 14 cycles plus 4.1 ms.
// - bit0=1, start-up 11: wake 16K cycles; reset 14 cycles plus 65 ms.
// - programmed divide-by-eight fuse divides the oscillator by eight for the system clock.
// - wake from sleep counts only start-up cycles; reset adds the time-out.
// - reset time-out counts watchdog oscillator cycles: 512 or 8K.
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps

module css_top
#(
  parameter int WAKE_LONG_CYCLES = css_pkg::DEF_WAKE_LONG,
  parameter int TOUT_LONG_CYCLES = css_pkg::DEF_TOUT_LONG,
  parameter int CNT_W = css_pkg::DEF_CNT_W
)
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [css_pkg::AXI_AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [css_pkg::AXI_DW-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [css_pkg::AXI_AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [css_pkg::AXI_DW-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic OSC_OUTPUT_PIN,
  input wire logic WDT_OSC_IN,
  input wire logic WAKE_IN,
  output logic SYS_CLK_TICK,
  output logic CLOCK_STABLE,
  output logic INT_RESET_HOLD,
  output logic OSC_LOW_POWER_SEL,
  output logic OSC_FULL_SWING_SEL,
  output logic [1:0] OSC_RANGE
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int NSYNC = 3;
  localparam int SYN_OSC = 0;
  localparam int SYN_WDT = 1;
  localparam int SYN_WAKE = 2;

  css_pkg::css_fuse_t fuse_reg;
  css_pkg::css_start_t start_reg;
  css_pkg::css_start_t start_dec;
  css_pkg::css_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [css_pkg::DIV_W-1:0] div_reg;
  logic [NSYNC-1:0] in_meta_reg;
  logic [NSYNC-1:0] in_sync_reg;
  logic [NSYNC-1:0] in_prev_reg;
  logic osc_edge;
  logic wdt_edge;
  logic wake_edge;
  logic restart_req_reg;
  logic sleep_req_reg;
  logic wake_req_reg;
  logic sel_low_power;
  logic sel_full_swing;
  logic xtal_sel;
  logic div8_on;
  logic [CNT_W-1:0] wake_last;
  logic [CNT_W-1:0] tout_last;
  logic [CNT_W-1:0] rst14_last;
  logic tout_none;
  logic aw_got_reg;
  logic w_got_reg;
  logic [css_pkg::AXI_AW-1:0] aw_addr_reg;
  logic [css_pkg::AXI_DW-1:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [css_pkg::AXI_DW-1:0] rdata_reg;
  logic do_write;
  logic [css_pkg::AXI_DW-1:0] status_word;
  logic tick_reg;
  logic stable_reg;
  logic hold_reg;
  logic lp_reg;
  logic fs_reg;
  logic [1:0] range_reg;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // oscillator, watchdog oscillator and wake pin all cross into CLK; the
  // oscillators must run well below CLK/2 or edges are lost
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      in_meta_reg <= '0;
      in_sync_reg <= '0;
      in_prev_reg <= '0;
    end
    else
    begin
      in_meta_reg <= {WAKE_IN, WDT_OSC_IN, OSC_OUTPUT_PIN};
      in_sync_reg <= in_meta_reg;
      in_prev_reg <= in_sync_reg;
    end
  end

  // rising edges seen only after the second flop
  assign osc_edge = in_sync_reg[SYN_OSC] & ~in_prev_reg[SYN_OSC];
  assign wdt_edge = in_sync_reg[SYN_WDT] & ~in_prev_reg[SYN_WDT];
  assign wake_edge = in_sync_reg[SYN_WAKE] & ~in_prev_reg[SYN_WAKE];

  // ----------------------------------------------------------------
  // fuse decode
  // ----------------------------------------------------------------
  // source select and range come straight from the fuse image
  always_comb
  begin
    sel_low_power = fuse_reg.clock_source_select_fuses[css_pkg::SRC_LP_BIT];
    sel_full_swing = (fuse_reg.clock_source_select_fuses[3:1] == css_pkg::SRC_FULL_SWING);
    xtal_sel = sel_low_power | sel_full_swing;
    div8_on = ~fuse_reg.div8_n;
    // one table for both crystal kinds
    start_dec = css_pkg::css_decode(fuse_reg.clock_source_select_fuses[0],
      fuse_reg.startup_time_fuses);
  end

  // last count value of each phase, from the options latched at start
  always_comb
  begin
    case (start_reg.wake)
      css_pkg::WK_258: wake_last = CNT_W'(css_pkg::WAKE_SHORT - 1);
      css_pkg::WK_1K: wake_last = CNT_W'(css_pkg::WAKE_MID - 1);
      default: wake_last = CNT_W'(WAKE_LONG_CYCLES - 1);
    endcase
    case (start_reg.tout)
      css_pkg::TO_512: tout_last = CNT_W'(css_pkg::TOUT_SHORT - 1);
      css_pkg::TO_8K: tout_last = CNT_W'(TOUT_LONG_CYCLES - 1);
      default: tout_last = '0;
    endcase
    tout_none = (start_reg.tout == css_pkg::TO_NONE);
    rst14_last = CNT_W'(css_pkg::RESET_CK - 1);
  end

  // ----------------------------------------------------------------
  // start-up sequencer
  // ----------------------------------------------------------------
  // reset path: time-out on watchdog cycles, then 14 oscillator cycles;
  // wake path: oscillator start-up cycles only
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_reg <= css_pkg::CSS_START;
      cnt_reg <= '0;
      start_reg <= '{css_pkg::WK_16K, css_pkg::TO_8K};
    end
    else if (restart_req_reg)
    begin
      state_reg <= css_pkg::CSS_START;
      cnt_reg <= '0;
    end
    else
    begin
      case (state_reg)
        css_pkg::CSS_START:
        begin
          cnt_reg <= '0;
          start_reg <= start_dec; // fuses taken once per reset or restart pulse
          state_reg <= xtal_sel ? css_pkg::CSS_TOUT : css_pkg::CSS_OFF;
        end
        css_pkg::CSS_TOUT:
        begin
          if (tout_none)
            state_reg <= css_pkg::CSS_RST14;
          else if (wdt_edge)
          begin
            if (cnt_reg == tout_last)
            begin
              cnt_reg <= '0;
              state_reg <= css_pkg::CSS_RST14;
            end
            else
              cnt_reg <= cnt_reg + 1'b1;
          end
        end
        css_pkg::CSS_RST14:
        begin
          if (osc_edge)
          begin
            if (cnt_reg == rst14_last)
            begin
              cnt_reg <= '0;
              state_reg <= css_pkg::CSS_RUN;
            end
            else
              cnt_reg <= cnt_reg + 1'b1;
          end
        end
        css_pkg::CSS_RUN:
        begin
          if (sleep_req_reg)
            state_reg <= css_pkg::CSS_SLEEP;
        end
        css_pkg::CSS_SLEEP:
        begin
          cnt_reg <= '0;
          if (wake_edge | wake_req_reg)
            state_reg <= css_pkg::CSS_WAKE; // no time-out on wake
        end
        css_pkg::CSS_WAKE:
        begin
          if (osc_edge)
          begin
            if (cnt_reg == wake_last)
            begin
              cnt_reg <= '0;
              state_reg <= css_pkg::CSS_RUN;
            end
            else
              cnt_reg <= cnt_reg + 1'b1;
          end
        end
        css_pkg::CSS_OFF:
        begin
          cnt_reg <= '0;
        end
        default:
        begin
          state_reg <= css_pkg::CSS_START;
          cnt_reg <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // system clock prescaler
  // ----------------------------------------------------------------
  // one tick per oscillator edge, or per eighth edge when divided
  always_ff @(posedge CLK)
  begin
    if (RST || state_reg != css_pkg::CSS_RUN)
    begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      if (osc_edge)
        div_reg <= div_reg + 1'b1;
      tick_reg <= osc_edge & (~div8_on | (div_reg == css_pkg::DIV_LAST));
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  // stable and hold trail the state by one cycle; source selects and range trail the fuse image
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      stable_reg <= 1'b0;
      hold_reg <= 1'b0;
      lp_reg <= 1'b0;
      fs_reg <= 1'b0;
      range_reg <= '0;
    end
    else
    begin
      stable_reg <= (state_reg == css_pkg::CSS_RUN);
      hold_reg <= (state_reg == css_pkg::CSS_START) || (state_reg == css_pkg::CSS_TOUT)
        || (state_reg == css_pkg::CSS_RST14);
      lp_reg <= sel_low_power;
      fs_reg <= sel_full_swing;
      range_reg <= sel_low_power ? fuse_reg.clock_source_select_fuses[2:1] : 2'h0;
    end
  end

  assign SYS_CLK_TICK = tick_reg;
  assign CLOCK_STABLE = stable_reg;
  assign INT_RESET_HOLD = hold_reg;
  assign OSC_LOW_POWER_SEL = lp_reg;
  assign OSC_FULL_SWING_SEL = fs_reg;
  assign OSC_RANGE = range_reg;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // address and data taken in either order; response once both are held
  assign S_AXI_AWREADY = ~aw_got_reg & ~bvalid_reg;
  assign S_AXI_WREADY = ~w_got_reg & ~bvalid_reg;
  assign do_write = aw_got_reg & w_got_reg & ~bvalid_reg;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= css_pkg::RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_got_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
      if (do_write)
      begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        case ({aw_addr_reg[css_pkg::AXI_AW-1:2], 2'b00})
          css_pkg::REG_FUSE, css_pkg::REG_CTRL, css_pkg::REG_STATUS, css_pkg::REG_COUNT:
            bresp_reg <= css_pkg::RESP_OKAY;
          default:
            bresp_reg <= css_pkg::RESP_SLVERR;
        endcase
      end
      else if (bvalid_reg && S_AXI_BREADY)
        bvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;

  // fuse image and write-one control pulses; status and count ignore writes
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      fuse_reg <= css_pkg::FUSE_RESET;
      restart_req_reg <= 1'b0;
      sleep_req_reg <= 1'b0;
      wake_req_reg <= 1'b0;
    end
    else
    begin
      restart_req_reg <= 1'b0;
      sleep_req_reg <= 1'b0;
      wake_req_reg <= 1'b0;
      if (do_write && w_strb_reg[0])
      begin
        if ({aw_addr_reg[css_pkg::AXI_AW-1:2], 2'b00} == css_pkg::REG_FUSE)
          fuse_reg <= w_data_reg[css_pkg::FUSE_W-1:0];
        if ({aw_addr_reg[css_pkg::AXI_AW-1:2], 2'b00} == css_pkg::REG_CTRL)
        begin
          restart_req_reg <= w_data_reg[css_pkg::CTRL_RESTART_BIT];
          sleep_req_reg <= w_data_reg[css_pkg::CTRL_SLEEP_BIT];
          wake_req_reg <= w_data_reg[css_pkg::CTRL_WAKE_BIT];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_comb
  begin
    status_word = '0;
    status_word[css_pkg::ST_STATE_LSB +: 3] = state_reg;
    status_word[css_pkg::ST_LP_BIT] = lp_reg;
    status_word[css_pkg::ST_FS_BIT] = fs_reg;
    status_word[css_pkg::ST_RANGE_LSB +: 2] = range_reg;
    status_word[css_pkg::ST_STABLE_BIT] = stable_reg;
    status_word[css_pkg::ST_HOLD_BIT] = hold_reg;
    status_word[css_pkg::ST_DIV8_BIT] = div8_on;
    status_word[css_pkg::ST_WAKE_LSB +: 2] = start_reg.wake;
    status_word[css_pkg::ST_TOUT_LSB +: 2] = start_reg.tout;
  end

  assign S_AXI_ARREADY = ~rvalid_reg;

  // one cycle from address to data; unmapped reads return zero and SLVERR
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= css_pkg::RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= css_pkg::RESP_OKAY;
      case ({S_AXI_ARADDR[css_pkg::AXI_AW-1:2], 2'b00})
        css_pkg::REG_FUSE: rdata_reg <= css_pkg::AXI_DW'(fuse_reg);
        css_pkg::REG_CTRL: rdata_reg <= '0; // pulses read back as zero
        css_pkg::REG_STATUS: rdata_reg <= status_word;
        css_pkg::REG_COUNT: rdata_reg <= css_pkg::AXI_DW'(cnt_reg);
        default:
        begin
          rdata_reg <= '0;
          rresp_reg <= css_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_reg && S_AXI_RREADY)
      rvalid_reg <= 1'b0;
  end

  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

endmodule // css_top

/* File: bench/css_top_asserts.sv */
// concurrent checks on the ports of the crystal start-up select block
`timescale 1ns/1ps
// ----------------------------------------------------------------
// checker
// ----------------------------------------------------------------
module css_top_asserts
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic SYS_CLK_TICK,
  input wire logic CLOCK_STABLE,
  input wire logic INT_RESET_HOLD,
  input wire logic OSC_LOW_POWER_SEL,
  input wire logic OSC_FULL_SWING_SEL,
  input wire logic [1:0] OSC_RANGE
);
  logic [15:0] low_cnt_reg;

  // cycles spent without a stable clock; saturates so a long sleep cannot wrap it
  always_ff @(posedge CLK)
  begin
    if (RST || CLOCK_STABLE)
      low_cnt_reg <= 16'h0;
    else if (low_cnt_reg != 16'hFFFF)
      low_cnt_reg <= low_cnt_reg + 16'h1;
  end

  default clocking dcb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // selection outputs
  range_lp_a: assert property (!OSC_LOW_POWER_SEL |-> OSC_RANGE == 2'h0)
    else $error("range shown without low power source");
  fs_excl_a: assert property (OSC_FULL_SWING_SEL |-> !OSC_LOW_POWER_SEL)
    else $error("both oscillator kinds selected");
  // start-up sequencing: at least 14 osc edges, each at least 4 cycles apart
  stable_delay_a: assert property ($rose(CLOCK_STABLE) |-> low_cnt_reg >= 16'h34)
    else $error("clock declared stable too early");
  hold_stable_a: assert property (INT_RESET_HOLD |-> !CLOCK_STABLE)
    else $error("stable while reset hold active");
  tick_gap_a: assert property (SYS_CLK_TICK |=> !SYS_CLK_TICK [*3])
    else $error("system ticks too close together");
  // register slave handshakes
  bvalid_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  rvalid_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  wr_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write response late");
  rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && S_AXI_RRESP == css_pkg::RESP_OKAY)
    else $error("read answer late or bad");
  rd_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("address taken while read pending");
endmodule // css_top_asserts

bind css_top css_top_asserts u_css_top_asserts (
  .CLK(CLK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .SYS_CLK_TICK(SYS_CLK_TICK),
  .CLOCK_STABLE(CLOCK_STABLE), .INT_RESET_HOLD(INT_RESET_HOLD), .OSC_LOW_POWER_SEL(OSC_LOW_POWER_SEL),
  .OSC_FULL_SWING_SEL(OSC_FULL_SWING_SEL), .OSC_RANGE(OSC_RANGE));

/* File: bench/css_top_tb.sv */
// self-checking bench for the crystal start-up select block
`timescale 1ns/1ps
// ----------------------------------------------------------------
// bench
// ----------------------------------------------------------------
module css_top_tb;
  localparam int WL = 40;
  localparam int TL = 20;
  int wk_n[8] = '{258, 258, 1024, 1024, 1024, WL, WL, WL};
  int to_n[8] = '{512, TL, 0, 512, TL, 0, 512, TL};
  int code[8] = '{4, 8, 1, 5, 9, 2, 6, 10};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic osc = 1'b0;
  logic wdt = 1'b0;
  logic wake = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tick, stable, hold, lp, fs;
  logic [1:0] bresp, rresp, range;
  logic [31:0] rdata;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;

  css_top #(.WAKE_LONG_CYCLES(WL), .TOUT_LONG_CYCLES(TL)) u_css_top (
    .CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .OSC_OUTPUT_PIN(osc), .WDT_OSC_IN(wdt),
    .WAKE_IN(wake), .SYS_CLK_TICK(tick), .CLOCK_STABLE(stable), .INT_RESET_HOLD(hold),
    .OSC_LOW_POWER_SEL(lp), .OSC_FULL_SWING_SEL(fs), .OSC_RANGE(range));

  // clock, oscillator stand-ins (crystal 4 cycles, watchdog 6) and hang limit
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc % 2 == 1) osc <= ~osc;
    if (cyc % 3 == 2) wdt <= ~wdt;
    if (cyc == 60000)
    begin
      errors = errors + 1;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t saw %h expected %h", $time, got, exp);
    end
  endtask

  // readies are combinational, so they are sampled at the falling edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, da, dw;
    logic [1:0] r;
    da = 1'b0;
    dw = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw))
    begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da = da || ta;
      dw = dw || tw;
    end
    do @(negedge clk); while (!bvalid);
    r = bresp;
    @(posedge clk);
    bready <= 1'b0;
    check(32'(r), 32'h0);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    d = rdata;
    check(32'(rresp), 32'h0);
    @(posedge clk);
    rready <= 1'b0;
  endtask

  // cycles until the clock is declared stable, looked at on falling edges where outputs have settled
  task automatic measure(output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (!stable);
  endtask

  task automatic near(input int n, input int e);
    check(32'(n >= e - 12 && n <= e + 20), 32'h1);
  endtask

  task automatic ticks(input int len, output int t);
    t = 0;
    repeat (len) @(negedge clk) t += int'(tick);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] v;
    int n;
    int t;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(css_pkg::REG_FUSE, v);
    check(v, 32'h22);
    rd(css_pkg::REG_STATUS, v);
    check(32'(v[2:0]), 32'h6);
    // every upper select code, checked on the selection outputs
    // code 100 suits resonators only; the stand-in plays one there
    for (int u = 0; u < 8; u++)
    begin
      wr(css_pkg::REG_FUSE, 32'h70 | 32'(u << 1));
      repeat (3) @(negedge clk);
      check(32'(lp), 32'(u >= 4));
      check(32'(fs), 32'(u == 3));
      check(32'(range), u >= 4 ? 32'(u - 4) : 32'h0);
    end
    // every start-up code, alternating crystal kinds and divider setting
    // the 258-cycle codes run a resonator stand-in far below top speed
    for (int i = 0; i < 8; i++)
    begin
      wr(css_pkg::REG_FUSE, 32'({i[0] ^ i[2], i[1:0], i[1] ? 3'h3 : 3'h7, i[2]}));
      wr(css_pkg::REG_CTRL, 32'h1);
      repeat (2) @(negedge clk);
      check(32'(hold), 32'h1);
      check(32'(stable), 32'h0);
      measure(n);
      near(n, 6 * to_n[i] + 56);
      rd(css_pkg::REG_STATUS, v);
      check(32'(v[13:10]), 32'(code[i]));
      ticks(160, t);
      check(32'(t >= 39 && t <= 41), 32'(i[0] != i[2]));
      check(32'(t >= 4 && t <= 6), 32'(i[0] == i[2]));
      wr(css_pkg::REG_CTRL, 32'h2);
      ticks(40, t);
      check(32'(t <= 1), 32'h1);
      check(32'(stable), 32'h0);
      if (i == 7)
        wr(css_pkg::REG_CTRL, 32'h4);
      else
      begin
        @(posedge clk);
        wake <= 1'b1;
      end
      measure(n);
      @(posedge clk);
      wake <= 1'b0;
      near(n, 4 * wk_n[i] + 4);
      check(32'(hold), 32'h0);
    end
    summarize();
  end
endmodule // css_top_tb
